// file: rtl/adc_readout.sv
// conversion control and serial readout of a 12-bit successive-approximation converter
// assumes the converter core presents RESULT_CODE on SYS_CLK; start pin and serial clock are asynchronous
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - a falling start edge while tracking begins a conversion and puts track/hold into hold
// - busy rises at that falling edge and falls once the result is written to the fifo
// - start still low at conversion end sends the part into power-down
// - from power-down, the next rising start edge wakes the part
// - each of the first fifteen falling serial clock edges of a readout presents the next serial data bit
// - a readout is sixteen bits: four zeros then the twelve result bits
// - after the sixteenth falling edge the last bit holds, then output floats
// - bipolar parts code in two's complement, unipolar in straight binary
// - conversion lasts 3.8 us normally, 9.8 us after waking from sleep
module adc_readout
    import adc_readout_pkg::*;
(
    input wire logic SYS_CLK,                       // 20 MHz system clock
    input wire logic RST_B,                         // async reset, active low
    input wire logic CONVERSION_START_N,            // start pin, active low, asynchronous
    input wire logic SERIAL_CLK,                    // serial clock from controller, asynchronous
    input wire logic [RESULT_BITS-1:0] RESULT_CODE, // offset-binary code of the core
    input wire logic BIPOLAR,                       // variant select: 1 bipolar range
    output logic BUSY,                              // conversion in progress
    output logic TRACK_HOLD,                        // 1 while track/hold holds
    output logic POWER_DOWN,                        // part is powered down
    output logic SERIAL_DATA_OUT,                   // serial data pin, output value
    output logic SERIAL_DATA_OE                     // serial data pin drive enable
);

    // ********************************************************
    // state and carriers
    // ********************************************************
    readout_state_t cur_reg;
    readout_state_t cur_next;
    word_stream_if #(.WIDTH(WORD_BITS)) words ();

    logic conv_lvl;
    logic conv_fall;
    logic conv_rise;
    logic sclk_fall;
    logic conv_done;

    // bit [0] is the first synchroniser stage, bit [1] the second, bit [2] history
    assign conv_lvl = cur_reg.conv_sync[1];
    assign conv_fall = cur_reg.conv_sync[2] && !cur_reg.conv_sync[1];
    assign conv_rise = !cur_reg.conv_sync[2] && cur_reg.conv_sync[1];
    assign sclk_fall = cur_reg.sclk_sync[2] && !cur_reg.sclk_sync[1];
    assign conv_done = (cur_reg.cst == S_CONVERT) &&
                       (cur_reg.ccnt == (cur_reg.long_conv ? SLEEP_CONV_LAST : CONV_LAST));

    assign words.push_valid = (cur_reg.cst == S_STORE);
    assign words.push_data = code_word(cur_reg.result, BIPOLAR);
    assign words.pop_ready = (cur_reg.rdst == R_IDLE);

    result_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .port(words.store)
    );

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        cur_next = cur_reg;
        cur_next.conv_sync = {cur_reg.conv_sync[1:0], CONVERSION_START_N};
        cur_next.sclk_sync = {cur_reg.sclk_sync[1:0], SERIAL_CLK};

        // conversion control
        case (cur_reg.cst)
            S_TRACK: begin
                if (conv_fall) begin
                    cur_next.cst = S_CONVERT;
                    cur_next.hold = 1'b1;
                    cur_next.busy = 1'b1;
                    cur_next.ccnt = '0;
                end
            end
            S_CONVERT: begin
                // start edges during a conversion are ignored
                cur_next.ccnt = cur_reg.ccnt + 1'b1;
                if (conv_done) begin
                    cur_next.result = RESULT_CODE;
                    cur_next.long_conv = 1'b0;
                    cur_next.cst = S_STORE;
                end
            end
            S_STORE: begin
                // a full fifo keeps busy high: results are never dropped
                if (words.push_ready) begin
                    cur_next.busy = 1'b0;
                    cur_next.hold = 1'b0;
                    if (!conv_lvl) begin
                        cur_next.cst = S_SLEEP;
                        cur_next.pd = 1'b1;
                        cur_next.long_conv = 1'b1;
                    end else begin
                        cur_next.cst = S_TRACK;
                    end
                end
            end
            S_SLEEP: begin
                if (conv_rise) begin
                    cur_next.cst = S_TRACK;
                    cur_next.pd = 1'b0;
                end
            end
            default: begin
                cur_next.cst = S_TRACK;
            end
        endcase

        // serial readout
        case (cur_reg.rdst)
            R_IDLE: begin
                if (words.pop_valid) begin
                    cur_next.shift = words.pop_data;
                    cur_next.sdo = words.pop_data[WORD_BITS-1];
                    cur_next.oe = 1'b1;
                    cur_next.bits = '0;
                    cur_next.rdst = R_DRIVE;
                end
            end
            R_DRIVE: begin
                if (sclk_fall) begin
                    if (cur_reg.bits == LAST_BIT_IDX) begin
                        // last bit stays on the pin through the hold interval
                        cur_next.bits = '0;
                        cur_next.rdst = R_HOLD;
                    end else begin
                        cur_next.bits = cur_reg.bits + 1'b1;
                        cur_next.shift = {cur_reg.shift[WORD_BITS-2:0], 1'b0};
                        cur_next.sdo = cur_reg.shift[WORD_BITS-2];
                    end
                end
            end
            R_HOLD: begin
                if (cur_reg.bits == HOLD_LAST) begin
                    cur_next.oe = 1'b0;
                    cur_next.sdo = 1'b0;
                    cur_next.rdst = R_IDLE;
                end else begin
                    cur_next.bits = cur_reg.bits + 1'b1;
                end
            end
            default: begin
                cur_next.rdst = R_IDLE;
                cur_next.oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cur_reg <= STATE_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign BUSY = cur_reg.busy;
    assign TRACK_HOLD = cur_reg.hold;
    assign POWER_DOWN = cur_reg.pd;
    assign SERIAL_DATA_OUT = cur_reg.sdo;
    assign SERIAL_DATA_OE = cur_reg.oe;

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    start_busy_a: assert property (
        (cur_reg.cst == S_TRACK && conv_fall) |=> BUSY)
        else $error("busy did not rise after a start edge");

    start_hold_a: assert property (
        (cur_reg.cst == S_TRACK && conv_fall) |=> (TRACK_HOLD && BUSY) [*8])
        else $error("track/hold or busy dropped early after start");

    short_conv_a: assert property (
        (cur_reg.cst == S_TRACK && conv_fall && !cur_reg.long_conv) |=>
        ##75 cur_reg.cst == S_CONVERT ##1 cur_reg.cst == S_STORE)
        else $error("normal conversion length wrong");

    long_conv_a: assert property (
        (cur_reg.cst == S_TRACK && conv_fall && cur_reg.long_conv) |=>
        ##195 cur_reg.cst == S_CONVERT ##1 cur_reg.cst == S_STORE)
        else $error("conversion after wake length wrong");

    power_down_a: assert property (
        (cur_reg.cst == S_STORE && words.push_ready && !conv_lvl) |=> POWER_DOWN && !BUSY)
        else $error("no power-down with start low at end of conversion");

    stay_up_a: assert property (
        (cur_reg.cst == S_STORE && words.push_ready && conv_lvl) |=> !POWER_DOWN && !BUSY)
        else $error("powered down although start was high");

    wake_a: assert property (
        (POWER_DOWN && conv_rise) |=> !POWER_DOWN ##1 !POWER_DOWN)
        else $error("rising start edge did not wake the part");

    shift_bit_a: assert property (
        (cur_reg.rdst == R_DRIVE && sclk_fall && cur_reg.bits != LAST_BIT_IDX) |=>
        SERIAL_DATA_OUT == $past(cur_reg.shift[WORD_BITS-2]) && SERIAL_DATA_OE)
        else $error("serial data did not advance on falling serial clock");

    lead_zero_a: assert property (
        $rose(SERIAL_DATA_OE) |-> !SERIAL_DATA_OUT && $past(words.pop_data[WORD_BITS-1 -: LEAD_ZEROS]) == '0)
        else $error("readout word lacks leading zeros");

    release_a: assert property (
        (cur_reg.rdst == R_DRIVE && sclk_fall && cur_reg.bits == LAST_BIT_IDX) |=>
        SERIAL_DATA_OE && $stable(SERIAL_DATA_OUT) ##1 !SERIAL_DATA_OE)
        else $error("serial output not released after sixteenth edge");

    coding_a: assert property (
        words.push_valid |-> words.push_data[RESULT_BITS-1] == (cur_reg.result[RESULT_BITS-1] ^ BIPOLAR))
        else $error("result coding wrong for the selected range");

    // ********************************************************
    // span and framing checks
    // ********************************************************
    // busy and the hold switch are one span seen from two pins
    hold_busy_a: assert property (
        TRACK_HOLD == BUSY)
        else $error("track/hold and busy disagree");

    busy_rise_a: assert property (
        $rose(BUSY) |-> $past(conv_fall) && $past(cur_reg.cst) == S_TRACK)
        else $error("busy rose without a start edge");

    // together with short_conv_a and long_conv_a this pins the whole conversion span
    convert_stay_a: assert property (
        (cur_reg.cst == S_CONVERT && !conv_done) |=> cur_reg.cst == S_CONVERT && BUSY)
        else $error("conversion left before its count ran out");

    // a stalled store must keep busy high, or the next start would overwrite the result
    stall_busy_a: assert property (
        (cur_reg.cst == S_STORE && !words.push_ready) |=> BUSY && cur_reg.cst == S_STORE)
        else $error("busy fell while the result was still waiting");

    sleep_idle_a: assert property (
        POWER_DOWN |-> !BUSY && !TRACK_HOLD)
        else $error("busy or hold high in power-down");

    sleep_stay_a: assert property (
        (POWER_DOWN && !conv_rise) |=> POWER_DOWN)
        else $error("woke without a rising start edge");

    wake_long_a: assert property (
        $fell(POWER_DOWN) |-> cur_reg.long_conv)
        else $error("conversion after wake not marked long");

    first_bit_a: assert property (
        (cur_reg.rdst == R_IDLE && words.pop_valid) |=>
        SERIAL_DATA_OE && SERIAL_DATA_OUT == $past(words.pop_data[WORD_BITS-1]))
        else $error("first bit on the pin is not the msb");

    // while a frame is driven, the pin may only move on a detected falling serial clock edge
    bit_still_a: assert property (
        (cur_reg.rdst == R_DRIVE && !sclk_fall) |=> $stable(SERIAL_DATA_OUT) && SERIAL_DATA_OE)
        else $error("serial data moved without a falling serial clock");

    zero_run_a: assert property (
        (cur_reg.rdst == R_DRIVE && sclk_fall && cur_reg.bits < BIT_CNT_W'(LEAD_ZEROS - 1)) |=>
        !SERIAL_DATA_OUT)
        else $error("leading zero bit not zero");

    bits_range_a: assert property (
        cur_reg.rdst == R_DRIVE |-> cur_reg.bits <= LAST_BIT_IDX)
        else $error("more than sixteen bits in one frame");

    float_low_a: assert property (
        !SERIAL_DATA_OE |-> !SERIAL_DATA_OUT)
        else $error("released pin still shows a one");

    oe_drop_a: assert property (
        $fell(SERIAL_DATA_OE) |-> $past(cur_reg.rdst) == R_HOLD)
        else $error("pin released outside the hold interval");

    conv_seen_c: cover property (
        (cur_reg.cst == S_TRACK && conv_fall) ##[70:200] $fell(BUSY));
    sleep_wake_c: cover property (
        $rose(POWER_DOWN) ##[1:1000] $fell(POWER_DOWN));
    full_read_c: cover property (
        $rose(SERIAL_DATA_OE) ##[1:1000] $fell(SERIAL_DATA_OE));
    fifo_full_c: cover property (
        cur_reg.cst == S_STORE && !words.push_ready);
    stall_clear_c: cover property (
        (cur_reg.cst == S_STORE && !words.push_ready) ##[1:1000] $fell(BUSY));

endmodule // adc_readout
`default_nettype wire

// file: rtl/adc_readout_pkg.sv
// constants, types and reset values of the conversion and serial readout block
// assumes a 20 MHz system clock; every cycle count below is derived from that period
package adc_readout_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 3800;
    localparam int SLEEP_CONV_TIME_NS = 9800;
    localparam int DATA_HOLD_NS = 10;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_CONV_CYCLES = (SLEEP_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_RAW = DATA_HOLD_NS / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] SLEEP_CONV_LAST = CNT_W'(SLEEP_CONV_CYCLES - 1);

    // ********************************************************
    // word layout
    // ********************************************************
    localparam int RESULT_BITS = 12;
    localparam int LEAD_ZEROS = 4;
    localparam int WORD_BITS = LEAD_ZEROS + RESULT_BITS;
    localparam int FIFO_DEPTH = 32;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = BIT_CNT_W'(WORD_BITS - 1);
    localparam logic [BIT_CNT_W-1:0] HOLD_LAST = BIT_CNT_W'(HOLD_CYCLES - 1);

    // ********************************************************
    // state
    // ********************************************************
    typedef enum logic [1:0] {S_TRACK, S_CONVERT, S_STORE, S_SLEEP} conv_state_t;
    typedef enum logic [1:0] {R_IDLE, R_DRIVE, R_HOLD} read_state_t;

    typedef struct packed {
        logic [2:0] conv_sync;
        logic [2:0] sclk_sync;
        conv_state_t cst;
        logic [CNT_W-1:0] ccnt;
        logic long_conv;
        logic [RESULT_BITS-1:0] result;
        logic busy;
        logic hold;
        logic pd;
        read_state_t rdst;
        logic [BIT_CNT_W-1:0] bits;
        logic [WORD_BITS-1:0] shift;
        logic sdo;
        logic oe;
    } readout_state_t;

    // start pin and serial clock idle high and low respectively
    localparam readout_state_t STATE_RESET = '{
        conv_sync: 3'h7, sclk_sync: 3'h0, cst: S_TRACK, ccnt: '0, long_conv: 1'b0,
        result: '0, busy: 1'b0, hold: 1'b0, pd: 1'b0, rdst: R_IDLE, bits: '0,
        shift: '0, sdo: 1'b0, oe: 1'b0};

    // bipolar parts flip the msb of the offset-binary core code
    function automatic logic [WORD_BITS-1:0] code_word(input logic [RESULT_BITS-1:0] raw,
                                                       input logic bipolar);
        logic [RESULT_BITS-1:0] coded;
        coded = raw;
        coded[RESULT_BITS-1] = raw[RESULT_BITS-1] ^ bipolar;
        code_word = {{LEAD_ZEROS{1'b0}}, coded};
    endfunction

endpackage

// file: rtl/result_fifo.sv
// result fifo: flip-flop storage, valid/ready on both sides
// assumes DEPTH is a power of two and a synchronous user on clk
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,           // system clock
    input wire logic rst_b,         // async reset, active low
    word_stream_if.store port       // push and pop sides
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t cur_reg;
    fifo_state_t cur_next;
    logic do_push;
    logic do_pop;

    assign port.push_ready = (cur_reg.count != (AW+1)'(DEPTH));
    assign port.pop_valid = (cur_reg.count != '0);
    assign port.pop_data = cur_reg.mem[cur_reg.rd];
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop = port.pop_valid && port.pop_ready;

    always_comb begin
        cur_next = cur_reg;
        if (do_push) begin
            cur_next.mem[cur_reg.wr] = port.push_data;
            cur_next.wr = cur_reg.wr + 1'b1;
        end
        if (do_pop) begin
            cur_next.rd = cur_reg.rd + 1'b1;
        end
        if (do_push && !do_pop) begin
            cur_next.count = cur_reg.count + 1'b1;
        end else if (do_pop && !do_push) begin
            cur_next.count = cur_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end
endmodule // result_fifo
`default_nettype wire

// file: rtl/word_stream_if.sv
// valid/ready carrier between the readout logic and its result fifo
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 16) ();
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
    modport user (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
endinterface // word_stream_if
`default_nettype wire

// file: testbench/adc_host_model.sv
// host controller model: drives the start pin and serial clock, captures serial data
// assumes the bench calls its tasks at a falling system clock edge
`timescale 1ns/10ps
`default_nettype none
module adc_host_model
    import adc_readout_pkg::*;
(
    input wire logic sys_clk, // system clock, only used to pace waits
    output logic start_n,     // start pin, idles high
    output logic sclk,        // serial clock, low between frames
    input wire logic sdo,     // serial data value from the device
    input wire logic oe       // serial data drive enable
);
    logic last_bit;
    logic line_level;
    initial begin
        start_n = 1'b1;
        sclk = 1'b0;
        last_bit = 1'b0;
    end
    // a released line shows the inverse of the last bit, so a stale copy cannot pass
    always_comb line_level = oe ? sdo : ~last_bit;

    task automatic set_start(input logic level);
        start_n = level;
    endtask

    // ********************************************************
    // one 16-bit frame at 400 ns per serial clock, every edge 13 ns after a falling sys_clk edge
    // ********************************************************
    task automatic read_word(output logic [WORD_BITS-1:0] word, output logic ok);
        int n;
        ok = 1'b1;
        word = '0;
        n = 0;
        while (oe !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        #13;
        for (int i = 0; i < WORD_BITS; i++) begin
            sclk = 1'b1;
            #200;
            word = {word[WORD_BITS-2:0], line_level};
            ok &= (oe === 1'b1);
            last_bit = line_level;
            sclk = 1'b0;
            if (i < WORD_BITS - 1) begin
                #200;
            end
        end
        @(negedge sys_clk);
        ok &= (oe === 1'b1);
        n = 0;
        while (oe !== 1'b0 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        ok &= (oe === 1'b0);
    endtask
endmodule // adc_host_model
`default_nettype wire

// file: testbench/serial_adc_conversion_readout_tb.sv
// self-checking bench for the conversion and serial readout block
// assumes adc_readout, its fifo and the host model are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module serial_adc_conversion_readout_tb;
    import adc_readout_pkg::*;
    logic sys_clk;
    logic rst_b;
    logic [RESULT_BITS-1:0] result_code;
    logic bipolar;
    logic busy, track_hold, power_down, sdo, oe;
    wire start_n;
    wire sclk;
    int err_count;
    int total_checks;
    int cycles;

    adc_readout u_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .CONVERSION_START_N(start_n),
        .SERIAL_CLK(sclk), .RESULT_CODE(result_code), .BIPOLAR(bipolar), .BUSY(busy),
        .TRACK_HOLD(track_hold), .POWER_DOWN(power_down), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE(oe));
    adc_host_model u_host (.sys_clk(sys_clk), .start_n(start_n), .sclk(sclk), .sdo(sdo), .oe(oe));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ********************************************************
    // reporting
    // ********************************************************
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake ends the run long after the longest scenario should be done
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            tally_and_finish();
        end
    end

    function automatic logic [WORD_BITS-1:0] expected(input logic [RESULT_BITS-1:0] code, input logic bip);
        // bipolar reading is the core code measured from mid-scale
        expected = {4'h0, bip ? code - 12'h800 : code};
    endfunction

    // ********************************************************
    // conversion helper: returns how many cycles busy stood high
    // ********************************************************
    task automatic convert(input logic keep_low, output int len);
        int n;
        logic hold_bad;
        repeat (8) @(negedge sys_clk);
        u_host.set_start(1'b0);
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        check(busy === 1'b1 && track_hold === 1'b1, "busy or hold did not rise on start");
        hold_bad = 1'b0;
        len = 0;
        while (busy === 1'b1 && len < 400) begin
            if (!keep_low && (len == 2 || len == 32)) u_host.set_start(1'b1);
            if (!keep_low && len == 30) u_host.set_start(1'b0);
            hold_bad |= (track_hold !== busy);
            len++;
            @(negedge sys_clk);
        end
        check(!hold_bad, "track/hold differs from busy");
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset;
        check(busy === 1'b0 && track_hold === 1'b0 && power_down === 1'b0 && oe === 1'b0, "not idle after reset");
    endtask

    task automatic t_codes;
        int len;
        logic [WORD_BITS-1:0] w;
        logic ok;
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk);
            bipolar = k[1];
            result_code = k[0] ? 12'h801 : 12'h7fe;
            convert(1'b0, len);
            check(len == CONV_CYCLES + 1 && power_down === 1'b0, "conversion length or power-down");
            u_host.read_word(w, ok);
            check(ok, "frame drive or release timing");
            check(w === expected(result_code, bipolar), "word content or order");
        end
    endtask

    task automatic t_sleep;
        int len;
        int n;
        logic [WORD_BITS-1:0] w;
        logic ok;
        convert(1'b1, len);
        check(power_down === 1'b1, "no power-down with start held low");
        repeat (8) @(negedge sys_clk);
        u_host.set_start(1'b1);
        n = 0;
        while (power_down === 1'b1 && n < 6) begin
            @(negedge sys_clk);
            n++;
        end
        check(power_down === 1'b0, "no wake on rising start");
        convert(1'b0, len);
        check(len == SLEEP_CONV_CYCLES + 1, "conversion after wake not long");
        repeat (2) begin
            u_host.read_word(w, ok);
            check(ok && w === expected(result_code, bipolar), "word after sleep");
        end
    endtask

    // fill the fifo with the host stalled, then drain in order
    task automatic t_fill;
        int len;
        int n;
        logic [WORD_BITS-1:0] w;
        logic ok;
        @(negedge sys_clk);
        bipolar = 1'b0;
        for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
            result_code = 12'h100 + 12'(i);
            convert(1'b0, len);
            check((i < FIFO_DEPTH + 1) ? len == CONV_CYCLES + 1 : busy === 1'b1, "fifo stall");
        end
        for (int j = 0; j < FIFO_DEPTH + 2; j++) begin
            u_host.read_word(w, ok);
            check(ok && w === {4'h0, 12'h100 + 12'(j)}, "drained word");
            if (j == 0) begin
                n = 0;
                while (busy === 1'b1 && n < 20) begin
                    @(negedge sys_clk);
                    n++;
                end
                check(busy === 1'b0, "stalled conversion not released");
            end
        end
    endtask

    initial begin
        rst_b = 1'b0;
        result_code = 12'h000;
        bipolar = 1'b0;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_codes();
        t_sleep();
        t_fill();
        tally_and_finish();
    end
endmodule // serial_adc_conversion_readout_tb
`default_nettype wire
